// [rtl/smp_pkg.sv]
// smp_pkg: shared constants and carrier types for the strap/pin mux block
// assumes a single 125 MHz clock domain and active-high asynchronous reset
package smp_pkg;
	localparam int SMP_ADDR_W = 14;
	localparam int SMP_DATA_W = 24;
	localparam int SMP_HOST_W = 16;
	localparam int SMP_BYTE_ADDR_W = 8;
	localparam int SMP_BYTE_ADDR_LSB = 16;
	localparam int SMP_UPPER_LSB = 8;
	localparam int SMP_FLAG_N = 8;
	// strap index within the sampled strap vector
	localparam int SMP_STRAP_A = 0;
	localparam int SMP_STRAP_B = 1;
	localparam int SMP_STRAP_C = 2;
	localparam int SMP_STRAP_D = 3;
	localparam logic [3:0] SMP_STRAP_RST = 4'h0;
	localparam logic [7:0] SMP_FLAG_RST = 8'h00;
	// shared pin positions on the flag bank
	localparam int SMP_PIN_EDGE = 4;
	localparam int SMP_PIN_LVL0 = 5;
	localparam int SMP_PIN_LVL1 = 6;
	localparam int SMP_PIN_TWO = 7;
	// interrupt vector index order from bit 0: edge, lvl0, lvl1, two
	localparam int SMP_IRQ_N = 4;

	typedef enum logic {SMP_MAP_FULL, SMP_MAP_HOST} smp_map_t;

	typedef struct packed {
		logic [SMP_ADDR_W-1:0] addr;
		logic [SMP_DATA_W-1:0] wdata;
		logic data_oe;
		logic [SMP_BYTE_ADDR_W-1:0] byte_addr;
		logic byte_acc;
	} smp_core_bus_t;

	typedef struct packed {
		logic sel_n;
		logic latch;
		logic fetch_n;
		logic store_n;
	} smp_host_strb_t;

	// puts the byte address on the top data bits
	function automatic logic [SMP_DATA_W-1:0] smp_merge_byte(
		input logic [SMP_DATA_W-1:0] d,
		input logic [SMP_BYTE_ADDR_W-1:0] ba);
		logic [SMP_DATA_W-1:0] r;
		r = d;
		r[SMP_DATA_W-1:SMP_BYTE_ADDR_LSB] = ba;
		return r;
	endfunction
endpackage

// [rtl/smp_irq_pin.sv]
// smp_irq_pin: one shared interrupt/flag pin, edge or level detection
// assumes pin level is synchronous to mclk, active low request
`timescale 1ns/1ps
module smp_irq_pin
	import smp_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic pin_in,
	input wire logic edge_mode,
	input wire logic enable,
	input wire logic ack,
	output logic req
);
	logic prev_reg, prev_next;
	logic latch_reg, latch_next;

	always_comb begin
		prev_next = pin_in;
		latch_next = latch_reg;
		if (ack)
			latch_next = 1'b0;
		if (prev_reg && !pin_in)
			latch_next = 1'b1;
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			prev_reg <= 1'b1;
			latch_reg <= 1'b0;
		end else begin
			prev_reg <= prev_next;
			latch_reg <= latch_next;
		end
	end

	// level request follows the pin; edge request holds until taken
	assign req = enable & (edge_mode ? latch_reg : ~pin_in);
endmodule

// [rtl/smp_top.sv]
// smp_top: strap sampling, fixed pin map selection and shared flag/irq pins
// assumes the core drives core_bus/flag outputs and takes irq_vec pulses
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// What this block does
// - strap pins are sampled once, on the first clock edge after reset releases.
// - after reset the four strap pins act as flag pins 3 to 0.
// - the external bus pin function is fixed at reset and never changes.
// - serial port shared pins switch function under software at any time.
// - shared interrupt/flag pins keep both functions active together.
// - an enabled shared interrupt vectors whether driven outside or by flag.
// - ext_int_two is edge or level, level pins level only, edge_int edge.
// - the bus config strap picks the pin map until next reset.
// - full map serves byte transfers, host map serves host port transfers.
// - strap low drives a 14-bit address bus and a 24-bit data bus.
// - full map puts byte address on the upper 8 data bits.
// - strap high gives 16-bit host bus, one address bit, 16-bit data.
// - host map drives an open-drain acknowledge set by its strap.
module smp_top
	import smp_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic [SMP_FLAG_N-1:0] flag_pin_in,
	output logic [SMP_FLAG_N-1:0] flag_pin_out,
	output logic [SMP_FLAG_N-1:0] flag_pin_oe_n,
	input wire logic [SMP_FLAG_N-1:0] flag_dir_out,
	input wire logic [SMP_FLAG_N-1:0] flag_wdata,
	output logic [SMP_FLAG_N-1:0] flag_rdata,
	input wire logic [SMP_IRQ_N-1:0] interrupt_enable_mask,
	input wire logic ext_int_two_edge,
	input wire logic [SMP_IRQ_N-1:0] irq_ack,
	output logic [SMP_IRQ_N-1:0] irq_vec,
	input wire smp_core_bus_t core_bus,
	output logic [SMP_ADDR_W-1:0] ext_address_bus,
	output logic ext_address_oe_n,
	input wire logic [SMP_DATA_W-1:0] ext_data_in,
	output logic [SMP_DATA_W-1:0] ext_data_out,
	output logic [SMP_DATA_W-1:0] ext_data_oe_n,
	output logic [SMP_DATA_W-1:0] core_rdata,
	input wire logic [SMP_HOST_W-1:0] host_ad_in,
	output logic [SMP_HOST_W-1:0] host_ad_out,
	output logic [SMP_HOST_W-1:0] host_ad_oe_n,
	input wire smp_host_strb_t host_strb,
	output smp_host_strb_t host_strb_core,
	output logic [SMP_HOST_W-1:0] host_ad_core,
	input wire logic [SMP_HOST_W-1:0] host_rdata,
	input wire logic host_rdata_oe,
	input wire logic host_ack_core,
	output logic host_port_acknowledge_out,
	output logic host_port_acknowledge_oe_n,
	output logic host_ack_mode,
	input wire logic [1:0] sport_alt_sel,
	input wire logic [1:0] sport_alt_in,
	output logic [1:0] sport_alt_out,
	output logic host_mode,
	output logic [3:0] strap_held
);
	//////////////////////////////////////////////////////////////////////////
	// strap capture
	logic [3:0] strap_reg, strap_next;
	logic run_reg, run_next;
	smp_map_t map_reg, map_next;

	always_comb begin
		strap_next = strap_reg;
		map_next = map_reg;
		run_next = 1'b1;
		// first clocked edge after release freezes the straps
		if (!run_reg) begin
			strap_next = flag_pin_in[3:0];
			map_next = flag_pin_in[SMP_STRAP_C] ? SMP_MAP_HOST
				: SMP_MAP_FULL;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			strap_reg <= SMP_STRAP_RST;
			map_reg <= SMP_MAP_FULL;
			run_reg <= 1'b0;
		end else begin
			strap_reg <= strap_next;
			map_reg <= map_next;
			run_reg <= run_next;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// shared interrupt/flag pins
	logic [SMP_IRQ_N-1:0] irq_req;
	logic [SMP_IRQ_N-1:0] irq_edge_sel;
	logic [SMP_IRQ_N-1:0] irq_pin;
	logic [SMP_IRQ_N-1:0] irq_prev_reg, irq_prev_next;

	// flags driven by the device loop back into the detector
	assign irq_pin = {flag_pin_in[SMP_PIN_TWO], flag_pin_in[SMP_PIN_LVL1],
		flag_pin_in[SMP_PIN_LVL0], flag_pin_in[SMP_PIN_EDGE]};
	assign irq_edge_sel = {ext_int_two_edge, 1'b0, 1'b0, 1'b1};

	genvar gi;
	generate
		for (gi = 0; gi < SMP_IRQ_N; gi++) begin : g_irq
			smp_irq_pin u_pin (
				.mclk(mclk),
				.rst(rst),
				.pin_in(irq_pin[gi]),
				.edge_mode(irq_edge_sel[gi]),
				.enable(interrupt_enable_mask[gi] & run_reg),
				.ack(irq_ack[gi]),
				.req(irq_req[gi])
			);
		end
	endgenerate

	// one vector pulse per new request
	logic [SMP_IRQ_N-1:0] vec_reg, vec_next;

	always_comb begin
		irq_prev_next = irq_req;
		vec_next = irq_req & ~irq_prev_reg;
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			irq_prev_reg <= '0;
			vec_reg <= '0;
		end else begin
			irq_prev_reg <= irq_prev_next;
			vec_reg <= vec_next;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// output registers
	logic [SMP_ADDR_W-1:0] a_reg, a_next;
	logic a_oe_reg, a_oe_next;
	logic [SMP_DATA_W-1:0] d_reg, d_next, doe_reg, doe_next;
	logic [SMP_DATA_W-1:0] drd_reg, drd_next;
	logic [SMP_HOST_W-1:0] h_reg, h_next, hoe_reg, hoe_next;
	logic [SMP_HOST_W-1:0] hcore_reg, hcore_next;
	smp_host_strb_t hs_reg, hs_next;
	smp_host_strb_t idle_strb;
	logic hm;

	assign idle_strb = '{sel_n: 1'b1, latch: 1'b0, fetch_n: 1'b1,
		store_n: 1'b1};
	assign hm = (map_reg == SMP_MAP_HOST);

	always_comb begin
		a_next = '0;
		a_oe_next = 1'b1;
		d_next = '0;
		doe_next = {SMP_DATA_W{1'b1}};
		drd_next = ext_data_in;
		h_next = '0;
		hoe_next = {SMP_HOST_W{1'b1}};
		hcore_next = '0;
		hs_next = idle_strb;
		case (map_reg)
		SMP_MAP_FULL: begin
			a_next = core_bus.addr;
			a_oe_next = ~run_reg;
			d_next = core_bus.wdata;
			if (core_bus.byte_acc) begin
				d_next = smp_merge_byte(core_bus.wdata,
					core_bus.byte_addr);
			end
			doe_next = {SMP_DATA_W{~(core_bus.data_oe | core_bus.byte_acc)}};
		end
		SMP_MAP_HOST: begin
			a_next = {{(SMP_ADDR_W-1){1'b0}}, core_bus.addr[0]};
			a_oe_next = ~run_reg;
			d_next = {core_bus.wdata[SMP_DATA_W-1:SMP_UPPER_LSB],
				{SMP_UPPER_LSB{1'b0}}};
			doe_next = {{SMP_HOST_W{~core_bus.data_oe}},
				{SMP_UPPER_LSB{1'b1}}};
			drd_next = {ext_data_in[SMP_DATA_W-1:SMP_UPPER_LSB],
				{SMP_UPPER_LSB{1'b0}}};
			hs_next = host_strb;
			hcore_next = host_ad_in;
			h_next = host_rdata;
			hoe_next = {SMP_HOST_W{~(host_rdata_oe & ~host_strb.sel_n)}};
		end
		default: begin
			a_oe_next = 1'b1;
		end
		endcase
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			a_reg <= '0;
			a_oe_reg <= 1'b1;
			d_reg <= '0;
			doe_reg <= {SMP_DATA_W{1'b1}};
			drd_reg <= '0;
			h_reg <= '0;
			hoe_reg <= {SMP_HOST_W{1'b1}};
			hcore_reg <= '0;
			hs_reg <= '{sel_n: 1'b1, latch: 1'b0, fetch_n: 1'b1,
				store_n: 1'b1};
		end else begin
			a_reg <= a_next;
			a_oe_reg <= a_oe_next;
			d_reg <= d_next;
			doe_reg <= doe_next;
			drd_reg <= drd_next;
			h_reg <= h_next;
			hoe_reg <= hoe_next;
			hcore_reg <= hcore_next;
			hs_reg <= hs_next;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// flag pins
	logic [SMP_FLAG_N-1:0] fout_reg, fout_next, foe_reg, foe_next;
	logic [SMP_FLAG_N-1:0] frd_reg, frd_next;

	always_comb begin
		fout_next = flag_wdata;
		// flags stay inputs until straps are frozen
		foe_next = run_reg ? ~flag_dir_out : {SMP_FLAG_N{1'b1}};
		frd_next = flag_pin_in;
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			fout_reg <= SMP_FLAG_RST;
			foe_reg <= {SMP_FLAG_N{1'b1}};
			frd_reg <= SMP_FLAG_RST;
		end else begin
			fout_reg <= fout_next;
			foe_reg <= foe_next;
			frd_reg <= frd_next;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// serial port shared pins
	logic [1:0] sp_reg, sp_next;

	always_comb begin
		// select is honoured on every cycle, not latched at reset
		sp_next = sport_alt_in & sport_alt_sel;
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			sp_reg <= '0;
		end else begin
			sp_reg <= sp_next;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// host acknowledge
	logic ack_reg, ack_next, ackoe_reg, ackoe_next, ackm_reg, ackm_next;

	always_comb begin
		ack_next = 1'b0;
		// follows the strap on the same edge that freezes it
		ackm_next = strap_next[SMP_STRAP_D];
		// open drain: only ever pulls low, and only in host map
		ackoe_next = ~(hm & host_ack_core);
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ack_reg <= 1'b0;
			ackoe_reg <= 1'b1;
			ackm_reg <= 1'b0;
		end else begin
			ack_reg <= ack_next;
			ackoe_reg <= ackoe_next;
			ackm_reg <= ackm_next;
		end
	end

	assign flag_pin_out = fout_reg;
	assign flag_pin_oe_n = foe_reg;
	assign flag_rdata = frd_reg;
	assign irq_vec = vec_reg;
	assign sport_alt_out = sp_reg;
	assign ext_address_bus = a_reg;
	assign ext_address_oe_n = a_oe_reg;
	assign ext_data_out = d_reg;
	assign ext_data_oe_n = doe_reg;
	assign core_rdata = drd_reg;
	assign host_ad_out = h_reg;
	assign host_ad_oe_n = hoe_reg;
	assign host_ad_core = hcore_reg;
	assign host_strb_core = hs_reg;
	assign host_port_acknowledge_out = ack_reg;
	assign host_port_acknowledge_oe_n = ackoe_reg;
	assign host_ack_mode = ackm_reg;
	assign host_mode = hm;
	assign strap_held = strap_reg;
endmodule

// [verification/smp_checker.sv]
// smp_checker: port-level assertions on smp_top
// assumes binding to smp_top, one clock, rst async high
`timescale 1ns/1ps
module smp_checker
	import smp_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic host_mode,
	input wire logic [3:0] strap_held,
	input wire logic host_ack_mode,
	input wire logic host_port_acknowledge_out,
	input wire smp_core_bus_t core_bus,
	input wire logic [SMP_ADDR_W-1:0] ext_address_bus,
	input wire logic [SMP_DATA_W-1:0] ext_data_out,
	input wire logic [SMP_DATA_W-1:0] ext_data_oe_n,
	input wire logic [SMP_FLAG_N-1:0] flag_pin_in,
	input wire logic [SMP_FLAG_N-1:0] flag_pin_oe_n,
	input wire logic [SMP_FLAG_N-1:0] flag_dir_out,
	input wire logic [SMP_IRQ_N-1:0] irq_vec,
	input wire logic [1:0] sport_alt_sel,
	input wire logic [1:0] sport_alt_in,
	input wire logic [1:0] sport_alt_out
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	a_straps_frozen: assert property (
		!$past(rst, 2) |-> $stable(strap_held)) else $error("straps moved");
	a_map_strap: assert property (
		host_mode == strap_held[SMP_STRAP_C]) else $error("map not strap");
	a_ack_config: assert property (
		host_ack_mode == strap_held[SMP_STRAP_D] &&
		host_port_acknowledge_out == 1'b0) else $error("ack config");
	a_flag_dir: assert property (
		!$past(rst, 2) |-> flag_pin_oe_n == ~$past(flag_dir_out))
		else $error("flag drive");
	a_full_addr: assert property (
		!$past(rst, 2) && !host_mode |->
		ext_address_bus == $past(core_bus.addr)) else $error("full addr");
	a_full_data: assert property (
		!$past(rst, 2) && !host_mode && $past(core_bus.data_oe) |->
		ext_data_out == ($past(core_bus.byte_acc) ?
		{$past(core_bus.byte_addr), $past(core_bus.wdata[15:0])} :
		$past(core_bus.wdata))) else $error("full data");
	a_host_bus: assert property (
		!$past(rst, 2) && host_mode |-> ext_data_oe_n[7:0] == 8'hff &&
		ext_address_bus[0] == $past(core_bus.addr[0]))
		else $error("host map");
	a_vec_single: assert property (
		(irq_vec & $past(irq_vec)) == '0) else $error("vec not pulse");
	a_level_cause: assert property (
		irq_vec[1] |-> !$past(flag_pin_in[SMP_PIN_LVL0]))
		else $error("level vec cause");
	a_sport_alt: assert property (
		!$past(rst) |-> sport_alt_out == $past(sport_alt_in & sport_alt_sel))
		else $error("sport alt");
endmodule
bind smp_top smp_checker chk (.*);

// [verification/smp_far.sv]
// smp_far: level seen at each flag pad
// assumes ext_lvl is what outside parts drive onto the pads
`timescale 1ns/1ps
module smp_far
	import smp_pkg::*;
(
	input wire logic [SMP_FLAG_N-1:0] pin_out,
	input wire logic [SMP_FLAG_N-1:0] pin_oe_n,
	input wire logic [SMP_FLAG_N-1:0] ext_lvl,
	output logic [SMP_FLAG_N-1:0] pin
);
	// own drive wins, so a flag output can raise its own interrupt
	always_comb begin
		for (int i = 0; i < SMP_FLAG_N; i++) begin
			pin[i] = pin_oe_n[i] ? ext_lvl[i] : pin_out[i];
		end
	end
endmodule

// [verification/tb.sv]
// tb: directed scenarios for smp_top with the flag pad model
// assumes 125 MHz mclk and the checker bound to smp_top
`timescale 1ns/1ps
module tb;
	import smp_pkg::*;
	logic mclk = 0;
	logic rst = 1;
	logic [7:0] flag_pin_in, flag_pin_out, flag_pin_oe_n, flag_rdata;
	logic [7:0] flag_dir_out = 0, flag_wdata = 0, ext_lvl = 8'hff;
	logic [3:0] interrupt_enable_mask = 0, irq_ack = 0, irq_vec;
	logic ext_int_two_edge = 0;
	smp_core_bus_t core_bus = '0;
	logic [13:0] ext_address_bus;
	logic ext_address_oe_n;
	logic [23:0] ext_data_in = 24'h5a3c96;
	logic [23:0] ext_data_out, ext_data_oe_n, core_rdata;
	logic [15:0] host_ad_in = 0, host_rdata = 0;
	logic [15:0] host_ad_out, host_ad_oe_n, host_ad_core;
	smp_host_strb_t host_strb = 4'hb, host_strb_core;
	logic host_rdata_oe = 0, host_ack_core = 0, host_ack_mode;
	logic host_port_acknowledge_out, host_port_acknowledge_oe_n;
	logic [1:0] sport_alt_sel = 0, sport_alt_in = 0, sport_alt_out;
	logic host_mode;
	logic [3:0] strap_held;
	int failures = 0, num_checks = 0, cycles = 0, n;
	always #4 mclk = ~mclk;
	smp_top uut (.*);
	smp_far far (.pin_out(flag_pin_out), .pin_oe_n(flag_pin_oe_n),
		.ext_lvl(ext_lvl), .pin(flag_pin_in));
	////////////////////////////////////////////////////////////////////////
	task tick(input int k);
		repeat (k) @(posedge mclk);
		#1;
	endtask
	task chk(input logic [23:0] got, input logic [23:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask
	// straps stay on the pads through the capture edge, then flip
	task do_reset(input logic [3:0] s);
		@(posedge mclk);
		rst <= 1;
		ext_lvl <= {4'hf, s};
		repeat (8) @(posedge mclk);
		rst <= 0;
		repeat (2) @(posedge mclk);
		ext_lvl <= {4'hf, ~s};
		tick(3);
		chk(strap_held, s);
		chk(flag_rdata, {4'hf, ~s});
	endtask
	task irq_count(input int k);
		n = 0;
		repeat (6) begin
			tick(1);
			if (irq_vec[k] === 1'b1)
				n++;
		end
	endtask
	////////////////////////////////////////////////////////////////////////
	task t_full();
		do_reset(4'h9);
		chk(host_mode, 0);
		chk(host_ack_mode, 1);
		@(posedge mclk);
		core_bus <= '{14'h2a5a, 24'hc35a96, 1'b1, 8'h00, 1'b0};
		tick(2);
		chk(ext_address_bus, 14'h2a5a);
		chk(ext_address_oe_n, 0);
		chk(ext_data_out, 24'hc35a96);
		chk(core_rdata, 24'h5a3c96);
		chk(ext_data_oe_n, 24'h000000);
		@(posedge mclk);
		core_bus <= '{14'h0155, 24'hc35a96, 1'b1, 8'h7e, 1'b1};
		tick(2);
		chk(ext_data_out, 24'h7e5a96);
		chk(strap_held, 4'h9);
	endtask
	task t_host();
		do_reset(4'h4);
		chk(host_mode, 1);
		chk(host_ack_mode, 0);
		@(posedge mclk);
		host_strb <= 4'h7;
		host_ad_in <= 16'h1234;
		core_bus <= '{14'h3fff, 24'hffffff, 1'b1, 8'h00, 1'b0};
		tick(2);
		chk(host_strb_core, 4'h7);
		chk(host_ad_core, 16'h1234);
		chk(ext_data_oe_n[7:0], 8'hff);
		chk(ext_address_bus, 14'h0001);
		chk(core_rdata, 24'h5a3c00);
		@(posedge mclk);
		host_strb <= 4'h1;
		host_rdata <= 16'hc3a5;
		host_rdata_oe <= 1;
		host_ack_core <= 1;
		tick(2);
		chk(host_ad_out, 16'hc3a5);
		chk(host_ad_oe_n, 16'h0000);
		chk(host_port_acknowledge_oe_n, 0);
		chk(host_port_acknowledge_out, 0);
		@(posedge mclk);
		host_strb <= 4'hb;
		host_rdata_oe <= 0;
		host_ack_core <= 0;
		tick(2);
		chk(host_port_acknowledge_oe_n, 1);
		chk(host_ad_oe_n, 16'hffff);
	endtask
	task t_irq();
		@(posedge mclk);
		interrupt_enable_mask <= 4'h1;
		ext_lvl[4] <= 0;
		irq_count(0);
		chk(n, 1);
		@(posedge mclk);
		irq_ack <= 4'h1;
		ext_lvl[4] <= 1;
		@(posedge mclk);
		irq_ack <= 4'h0;
		interrupt_enable_mask <= 4'h2;
		flag_dir_out[5] <= 1;
		flag_wdata[5] <= 0;
		irq_count(1);
		chk(n, 1);
		chk(flag_rdata[5], 0);
		chk(flag_pin_oe_n[5], 0);
		chk(flag_pin_out[5], 0);
		@(posedge mclk);
		interrupt_enable_mask <= 4'h0;
		ext_lvl[6] <= 0;
		irq_count(2);
		chk(n, 0);
		@(posedge mclk);
		sport_alt_sel <= 2'b01;
		sport_alt_in <= 2'b11;
		tick(2);
		chk(sport_alt_out, 2'b01);
	endtask
	// ext_int_two: edge mode holds one request, level mode repeats
	task t_two();
		@(posedge mclk);
		interrupt_enable_mask <= 4'h8;
		ext_int_two_edge <= 1;
		ext_lvl[7] <= 0;
		irq_count(3);
		chk(n, 1);
		@(posedge mclk);
		ext_lvl[7] <= 1;
		@(posedge mclk);
		ext_lvl[7] <= 0;
		irq_count(3);
		chk(n, 0);
		@(posedge mclk);
		irq_ack <= 4'h8;
		ext_int_two_edge <= 0;
		ext_lvl[7] <= 1;
		@(posedge mclk);
		irq_ack <= 4'h0;
		ext_lvl[7] <= 0;
		irq_count(3);
		chk(n, 1);
		@(posedge mclk);
		ext_lvl[7] <= 1;
		@(posedge mclk);
		ext_lvl[7] <= 0;
		irq_count(3);
		chk(n, 1);
	endtask
	////////////////////////////////////////////////////////////////////////
	task print_verdict();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 2000) begin
			failures++;
			print_verdict();
		end
	end
	initial begin
		t_full();
		t_host();
		t_irq();
		t_two();
		print_verdict();
	end
endmodule
